// >>> hw/ptpin_pkg.sv
// Shared constants and types for the port T pin control block
package ptpin_pkg;

    // ----------------------------------------------------------------
    // Widths and types
    // ----------------------------------------------------------------
    localparam int ADDR_W  = 16;
    localparam int DATA_W  = 8;
    localparam int PT_W    = 4;

    typedef logic [ADDR_W-1:0] ptpin_addr_t;
    typedef logic [DATA_W-1:0] ptpin_data_t;
    typedef logic [PT_W-1:0]   ptpin_pins_t;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam ptpin_addr_t OFF_PT_DATA  = 16'h0240;
    localparam ptpin_addr_t OFF_PT_DIR   = 16'h0244;
    localparam ptpin_addr_t OFF_PT_INPUT = 16'h0248;
    localparam ptpin_addr_t OFF_CLK_CTRL = 16'h024c;
    localparam ptpin_addr_t OFF_MISC     = 16'h0250;
    localparam ptpin_addr_t OFF_IRQ_CTRL = 16'h0254;
    localparam ptpin_addr_t OFF_TEST     = 16'h0258;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int BIT_CLK_DIS   = 7;
    localparam int BIT_OCP_EN    = 7;
    localparam int BIT_EDGE_SEL  = 7;
    localparam int BIT_IRQ_CON   = 6;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam ptpin_pins_t RST_PT_DATA  = 4'h0;
    localparam ptpin_pins_t RST_PT_DIR   = 4'h0;
    localparam logic        RST_CLK_DIS  = 1'b0;
    localparam logic        RST_OCP_EN   = 1'b0;
    localparam logic        RST_EDGE_SEL = 1'b0;
    localparam logic        RST_IRQ_CON  = 1'b1;
    localparam ptpin_data_t RST_TEST     = 8'h00;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic logic ptpin_hit(input ptpin_addr_t addr,
                                       input ptpin_addr_t off);
        return addr == off;
    endfunction : ptpin_hit

endpackage : ptpin_pkg

// >>> hw/ptpin_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module ptpin_sync #(
    parameter int W = 1
) (
    input  wire logic         i_ref_clk,
    input  wire logic         i_sys_rst,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            meta_q <= '0;
            o_sync <= '0;
        end
        else
        begin
            meta_q <= i_async;
            o_sync <= meta_q;
        end
    end
endmodule : ptpin_sync

// >>> hw/ptpin_mux.sv
// Priority selection of one port T pin among its functions
`timescale 1ns/1ps
module ptpin_mux (
    input  wire logic i_pri_a_en,
    input  wire logic i_pri_a_out,
    input  wire logic i_pri_a_drive,
    input  wire logic i_pri_b_en,
    input  wire logic i_pri_b_out,
    input  wire logic i_pri_b_drive,
    input  wire logic i_tim_en,
    input  wire logic i_tim_out,
    input  wire logic i_pwm_en,
    input  wire logic i_pwm_out,
    input  wire logic i_dir,
    input  wire logic i_data,
    output logic      o_out,
    output logic      o_drive
);
    // Highest owner first, general-purpose last
    assign o_out   = i_pri_a_en ? i_pri_a_out :
                     i_pri_b_en ? i_pri_b_out :
                     i_tim_en   ? i_tim_out   :
                     i_pwm_en   ? i_pwm_out   :
                     i_data;
    assign o_drive = i_pri_a_en ? i_pri_a_drive :
                     i_pri_b_en ? i_pri_b_drive :
                     (i_tim_en | i_pwm_en) ? 1'b1 :
                     i_dir;
endmodule : ptpin_mux

// >>> hw/ptpin_top.sv
// Port T, bus clock output and interrupt pin control
`timescale 1ns/1ps
module ptpin_top
    import ptpin_pkg::*;
(
    input  wire logic                   i_ref_clk,
    input  wire logic                   i_sys_rst,
    input  wire logic                   i_special_mode,
    input  wire ptpin_pkg::ptpin_addr_t i_addr,
    input  wire ptpin_pkg::ptpin_data_t i_wr_data,
    input  wire logic                   i_wr_en,
    input  wire logic                   i_rd_en,
    output ptpin_pkg::ptpin_data_t      o_rd_data,
    output logic                        o_bus_clock_out_pin,
    output logic                        o_overcurrent_detect_enable,
    input  wire logic                   i_irq_pin,
    input  wire logic                   i_irq_service,
    output logic                        o_irq_request,
    input  wire ptpin_pkg::ptpin_pins_t i_pt_pin,
    output ptpin_pkg::ptpin_pins_t      o_pt_out,
    output ptpin_pkg::ptpin_pins_t      o_pt_oe_n,
    input  wire logic                   i_spi_en,
    input  wire logic [1:0]             i_spi_out,
    input  wire logic [1:0]             i_spi_drive,
    input  wire logic [1:0]             i_lin_transceiver_en,
    input  wire logic [1:0]             i_lin_transceiver_out,
    input  wire logic [1:0]             i_lin_transceiver_drive,
    input  wire logic                   i_serial_interface_zero_en,
    input  wire logic [1:0]             i_serial_interface_zero_out,
    input  wire logic [1:0]             i_serial_interface_zero_drive,
    input  wire logic                   i_lin_direct_transmit_bit_en,
    input  wire logic                   i_lin_direct_transmit_bit,
    input  wire ptpin_pkg::ptpin_pins_t i_timer_compare_en,
    input  wire ptpin_pkg::ptpin_pins_t i_timer_compare_out,
    input  wire ptpin_pkg::ptpin_pins_t i_pwm_en,
    input  wire ptpin_pkg::ptpin_pins_t i_pwm_out,
    input  wire ptpin_pkg::ptpin_pins_t i_high_side_driver_claim,
    input  wire ptpin_pkg::ptpin_pins_t i_low_side_driver_claim,
    input  wire ptpin_pkg::ptpin_pins_t i_lin_receive_data_claim,
    output ptpin_pkg::ptpin_pins_t      o_timer_capture_in
);
    import ptpin_pkg::*;

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    ptpin_pins_t pt_data_q, pt_data_d;
    ptpin_pins_t pt_dir_q, pt_dir_d;
    logic        clk_dis_q, clk_dis_d;
    logic        ocp_en_q, ocp_en_d;
    logic        edge_sel_q, edge_sel_d;
    logic        edge_once_q, edge_once_d;
    logic        irq_con_q, irq_con_d;
    ptpin_data_t test_q, test_d;
    logic        irq_prev_q;
    logic        edge_latch_q, edge_latch_d;
    logic        clk_pin_d;
    logic        irq_req_d;
    ptpin_data_t rd_data_d;
    ptpin_pins_t pt_out_d, pt_oe_n_d, capture_d;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [PT_W:0] pins_raw;
    logic [PT_W:0] pins_sync;
    ptpin_pins_t   pt_sync;
    logic          irq_sync;

    // Irq pin inverted so reset reads as idle high
    assign pins_raw = {~i_irq_pin, i_pt_pin};

    ptpin_sync #(
        .W (PT_W + 1)
    ) u_sync (
        .i_ref_clk (i_ref_clk),
        .i_sys_rst (i_sys_rst),
        .i_async   (pins_raw),
        .o_sync    (pins_sync)
    );

    assign pt_sync  = pins_sync[PT_W-1:0];
    assign irq_sync = ~pins_sync[PT_W];

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    wire wr_data  = i_wr_en & ptpin_hit(i_addr, OFF_PT_DATA);
    wire wr_dir   = i_wr_en & ptpin_hit(i_addr, OFF_PT_DIR);
    wire wr_clk   = i_wr_en & ptpin_hit(i_addr, OFF_CLK_CTRL);
    wire wr_misc  = i_wr_en & ptpin_hit(i_addr, OFF_MISC);
    wire wr_irq   = i_wr_en & ptpin_hit(i_addr, OFF_IRQ_CTRL);
    wire wr_test  = i_wr_en & ptpin_hit(i_addr, OFF_TEST);
    wire edge_ok  = i_special_mode | ~edge_once_q;
    wire test_ok  = i_special_mode;

    // ----------------------------------------------------------------
    // Register next values
    // ----------------------------------------------------------------
    assign pt_data_d  = wr_data ? i_wr_data[PT_W-1:0] : pt_data_q;
    assign pt_dir_d   = wr_dir  ? i_wr_data[PT_W-1:0] : pt_dir_q;
    assign clk_dis_d  = wr_clk  ? i_wr_data[BIT_CLK_DIS] : clk_dis_q;
    assign ocp_en_d   = wr_misc ? i_wr_data[BIT_OCP_EN] : ocp_en_q;
    assign edge_sel_d = (wr_irq & edge_ok) ? i_wr_data[BIT_EDGE_SEL]
                                           : edge_sel_q;
    assign edge_once_d = edge_once_q | (wr_irq & ~i_special_mode);
    assign irq_con_d  = wr_irq  ? i_wr_data[BIT_IRQ_CON] : irq_con_q;
    assign test_d     = (wr_test & test_ok) ? i_wr_data
                                            : test_q;

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    wire ptpin_pins_t pt_read = (pt_dir_q & pt_data_q) |
                                (~pt_dir_q & pt_sync);
    assign rd_data_d =
        !i_rd_en ? '0 :
        ptpin_hit(i_addr, OFF_PT_DATA)  ? {4'h0, pt_read} :
        ptpin_hit(i_addr, OFF_PT_DIR)   ? {4'h0, pt_dir_q} :
        ptpin_hit(i_addr, OFF_PT_INPUT) ? {4'h0, pt_sync} :
        ptpin_hit(i_addr, OFF_CLK_CTRL) ? {clk_dis_q, 7'h00} :
        ptpin_hit(i_addr, OFF_MISC)     ? {ocp_en_q, 7'h00} :
        ptpin_hit(i_addr, OFF_IRQ_CTRL) ? {edge_sel_q, irq_con_q,
                                           6'h00} :
        ptpin_hit(i_addr, OFF_TEST)     ? test_q : '0;

    // ----------------------------------------------------------------
    // Clock output and interrupt pin
    // ----------------------------------------------------------------
    assign clk_pin_d = clk_dis_q ? 1'b0
                                 : ~o_bus_clock_out_pin;
    wire irq_fall = irq_prev_q & ~irq_sync;
    assign edge_latch_d = (edge_sel_q & irq_fall) |
                          (edge_latch_q & ~i_irq_service);
    assign irq_req_d = irq_con_q &
                       (edge_sel_q ? edge_latch_q
                                   : ~irq_sync);

    // ----------------------------------------------------------------
    // Port T function selection
    // ----------------------------------------------------------------
    ptpin_pins_t tim_ok, pwm_ok, pri_a_en, pri_a_out, pri_a_drv;
    ptpin_pins_t pri_b_en, pri_b_out, pri_b_drv, mux_out, mux_drv;

    assign tim_ok = i_timer_compare_en & ~i_high_side_driver_claim &
                    ~i_low_side_driver_claim;
    assign pwm_ok = i_pwm_en & ~i_high_side_driver_claim &
                    ~i_low_side_driver_claim;
    assign pri_a_en  = {{2{i_spi_en}},
                        {2{i_serial_interface_zero_en}}};
    assign pri_a_out = {i_spi_out, i_serial_interface_zero_out};
    assign pri_a_drv = {i_spi_drive, i_serial_interface_zero_drive};
    assign pri_b_en  = {i_lin_transceiver_en,
                        i_lin_direct_transmit_bit_en, 1'b0};
    assign pri_b_out = {i_lin_transceiver_out,
                        i_lin_direct_transmit_bit, 1'b0};
    assign pri_b_drv = {i_lin_transceiver_drive, 1'b1, 1'b0};

    genvar g;
    generate
        for (g = 0; g < PT_W; g++)
        begin : g_pin
            ptpin_mux u_mux (
                .i_pri_a_en    (pri_a_en[g]),
                .i_pri_a_out   (pri_a_out[g]),
                .i_pri_a_drive (pri_a_drv[g]),
                .i_pri_b_en    (pri_b_en[g]),
                .i_pri_b_out   (pri_b_out[g]),
                .i_pri_b_drive (pri_b_drv[g]),
                .i_tim_en      (tim_ok[g]),
                .i_tim_out     (i_timer_compare_out[g]),
                .i_pwm_en      (pwm_ok[g]),
                .i_pwm_out     (i_pwm_out[g]),
                .i_dir         (pt_dir_q[g]),
                .i_data        (pt_data_q[g]),
                .o_out         (mux_out[g]),
                .o_drive       (mux_drv[g])
            );
        end
    endgenerate

    assign pt_out_d  = mux_out;
    assign pt_oe_n_d = ~mux_drv;
    assign capture_d = pt_sync & ~i_lin_receive_data_claim;

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            pt_data_q    <= RST_PT_DATA;
            pt_dir_q     <= RST_PT_DIR;
            clk_dis_q    <= RST_CLK_DIS;
            ocp_en_q     <= RST_OCP_EN;
            edge_sel_q   <= RST_EDGE_SEL;
            edge_once_q  <= 1'b0;
            irq_con_q    <= RST_IRQ_CON;
            test_q       <= RST_TEST;
        end
        else
        begin
            pt_data_q    <= pt_data_d;
            pt_dir_q     <= pt_dir_d;
            clk_dis_q    <= clk_dis_d;
            ocp_en_q     <= ocp_en_d;
            edge_sel_q   <= edge_sel_d;
            edge_once_q  <= edge_once_d;
            irq_con_q    <= irq_con_d;
            test_q       <= test_d;
        end
    end

    // ----------------------------------------------------------------
    // Pin state and outputs
    // ----------------------------------------------------------------
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            irq_prev_q          <= 1'b1;
            edge_latch_q        <= 1'b0;
            o_irq_request       <= 1'b0;
            o_bus_clock_out_pin <= 1'b0;
            o_rd_data           <= '0;
            o_pt_out            <= '0;
            o_pt_oe_n           <= '1;
            o_timer_capture_in  <= '0;
        end
        else
        begin
            irq_prev_q          <= irq_sync;
            edge_latch_q        <= edge_latch_d;
            o_irq_request       <= irq_req_d;
            o_bus_clock_out_pin <= clk_pin_d;
            o_rd_data           <= rd_data_d;
            o_pt_out            <= pt_out_d;
            o_pt_oe_n           <= pt_oe_n_d;
            o_timer_capture_in  <= capture_d;
        end
    end

    assign o_overcurrent_detect_enable = ocp_en_q;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    a_clk_out_runs: assert property (
        !i_sys_rst && !clk_dis_q
        |=> o_bus_clock_out_pin != $past(o_bus_clock_out_pin))
        else $error("clock output did not toggle");

    a_clk_out_off: assert property (
        clk_dis_q |=> !o_bus_clock_out_pin)
        else $error("clock output active while disabled");

    a_ocp_write: assert property (
        wr_misc |=> o_overcurrent_detect_enable == $past(i_wr_data[7]))
        else $error("over-current enable not written");

    a_edge_hold: assert property (
        edge_latch_q && !i_irq_service |=> edge_latch_q)
        else $error("edge latch lost before service");

    a_edge_set: assert property (
        edge_sel_q && irq_fall |=> edge_latch_q)
        else $error("falling edge not latched");

    a_level_req: assert property (
        !edge_sel_q && irq_con_q && !irq_sync |=> o_irq_request)
        else $error("low level gave no request");

    a_edge_once: assert property (
        !i_special_mode && edge_once_q && wr_irq
        |=> edge_sel_q == $past(edge_sel_q))
        else $error("edge select rewritten in normal mode");

    a_irq_discon: assert property (
        !irq_con_q |=> !o_irq_request)
        else $error("request while disconnected");

    a_test_lock: assert property (
        !i_special_mode && wr_test |=> test_q == $past(test_q))
        else $error("test register written in normal mode");

    a_read_mux: assert property (
        i_rd_en && ptpin_hit(i_addr, OFF_PT_DATA)
        |=> o_rd_data[3:0] == (($past(pt_dir_q) & $past(pt_data_q)) |
                               (~$past(pt_dir_q) & $past(pt_sync))))
        else $error("port data read wrong");

    a_gpio_drive: assert property (
        pri_a_en == '0 && pri_b_en == '0 && tim_ok == '0 &&
        pwm_ok == '0 |=> o_pt_out == $past(pt_data_q) &&
                        o_pt_oe_n == ~$past(pt_dir_q))
        else $error("general-purpose output wrong");

    a_spi_first: assert property (
        i_spi_en |=> o_pt_out[3:2] == $past(i_spi_out))
        else $error("spi did not own pins 3-2");

    a_pwm_block: assert property (
        (i_high_side_driver_claim[0] || i_low_side_driver_claim[0]) &&
        pri_a_en[0] == 1'b0 |=> o_pt_oe_n[0] == ~$past(pt_dir_q[0]))
        else $error("pwm or timer reached a driver pin");

    a_serial_first: assert property (
        i_serial_interface_zero_en
        |=> o_pt_out[1:0] == $past(i_serial_interface_zero_out) &&
            o_pt_oe_n[1:0] == ~$past(i_serial_interface_zero_drive))
        else $error("serial interface did not own pins 1-0");

    a_txbit_pin1: assert property (
        !i_serial_interface_zero_en && i_lin_direct_transmit_bit_en
        |=> o_pt_out[1] == $past(i_lin_direct_transmit_bit) &&
            !o_pt_oe_n[1])
        else $error("transmit bit did not own pin 1");

    a_tim_over_gp: assert property (
        !pri_a_en[2] && !pri_b_en[2] && tim_ok[2]
        |=> o_pt_out[2] == $past(i_timer_compare_out[2]) && !o_pt_oe_n[2])
        else $error("timer did not override pin 2");

    a_cap_masked: assert property (
        i_lin_receive_data_claim != '0
        |=> (o_timer_capture_in & $past(i_lin_receive_data_claim)) == '0)
        else $error("capture reached a receive pin");

    a_cmp_lsd_off: assert property (
        i_low_side_driver_claim[1] && !pri_a_en[1] && !pri_b_en[1]
        |=> o_pt_oe_n[1] == ~$past(pt_dir_q[1]))
        else $error("compare reached a low-side pin");

endmodule : ptpin_top

// >>> dv/ptpin_pin_model.sv
// Pad model for port T: the block or an outside driver sets each pin
`timescale 1ns/1ps
module ptpin_pin_model
    import ptpin_pkg::*;
(
    input  wire ptpin_pkg::ptpin_pins_t i_pt_out,
    input  wire ptpin_pkg::ptpin_pins_t i_pt_oe_n,
    input  wire ptpin_pkg::ptpin_pins_t i_ext_level,
    output ptpin_pkg::ptpin_pins_t      o_pt_pin
);
    // ------------------------------------------------------------
    // Pin level: block drive wins, else the outside driver
    // ------------------------------------------------------------
    assign o_pt_pin = (~i_pt_oe_n & i_pt_out) | (i_pt_oe_n & i_ext_level);
endmodule : ptpin_pin_model

// >>> dv/ptpin_top_tb.sv
// Self-checking bench for the port T pin control block
`timescale 1ns/1ps
module ptpin_top_tb;
    import ptpin_pkg::*;
    logic        clk = 0, rst = 1, spm = 0, wr = 0, rd = 0, svc = 0;
    logic        irq = 1, spi_en = 0, sci_en = 0, ldt_en = 0, ldt = 0;
    ptpin_addr_t addr = '0;
    ptpin_data_t wdat = '0, rdat;
    logic [1:0]  spi_o = 0, spi_d = 0, lin_en = 0, lin_o = 0, lin_d = 0;
    logic [1:0]  sci_o = 0, sci_d = 0;
    ptpin_pins_t tce = 0, tco = 0, pwe = 0, pwo = 0, hs = 0, ls = 0;
    ptpin_pins_t lrx = 0, ext = 0, dir, dat, epin;
    ptpin_pins_t pin, pout, poe, cap;
    logic        ckp, ocp, req;
    logic [7:0]  e;
    int          fail_count = 0, num_checks = 0, cyc = 0;
    always #5 clk = ~clk;
    ptpin_top dut_u (.i_ref_clk(clk), .i_sys_rst(rst), .i_special_mode(spm),
        .i_addr(addr), .i_wr_data(wdat), .i_wr_en(wr), .i_rd_en(rd),
        .o_rd_data(rdat), .o_bus_clock_out_pin(ckp),
        .o_overcurrent_detect_enable(ocp), .i_irq_pin(irq),
        .i_irq_service(svc), .o_irq_request(req), .i_pt_pin(pin),
        .o_pt_out(pout), .o_pt_oe_n(poe), .i_spi_en(spi_en),
        .i_spi_out(spi_o), .i_spi_drive(spi_d), .i_lin_transceiver_en(lin_en),
        .i_lin_transceiver_out(lin_o), .i_lin_transceiver_drive(lin_d),
        .i_serial_interface_zero_en(sci_en),
        .i_serial_interface_zero_out(sci_o),
        .i_serial_interface_zero_drive(sci_d),
        .i_lin_direct_transmit_bit_en(ldt_en), .i_lin_direct_transmit_bit(ldt),
        .i_timer_compare_en(tce), .i_timer_compare_out(tco), .i_pwm_en(pwe),
        .i_pwm_out(pwo), .i_high_side_driver_claim(hs),
        .i_low_side_driver_claim(ls), .i_lin_receive_data_claim(lrx),
        .o_timer_capture_in(cap));
    ptpin_pin_model pad_u (.i_pt_out(pout), .i_pt_oe_n(poe),
        .i_ext_level(ext), .o_pt_pin(pin));
    // ------------------------------------------------------------
    // Checking, bus and closing tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr_reg(input ptpin_addr_t a, input ptpin_data_t d);
        @(posedge clk);
        wr <= 1; addr <= a; wdat <= d;
        @(posedge clk);
        wr <= 0;
    endtask : wr_reg
    task automatic rd_reg(input ptpin_addr_t a, output ptpin_data_t d);
        @(posedge clk);
        rd <= 1; addr <= a;
        @(posedge clk);
        rd <= 0;
        #1 d = rdat;
    endtask : rd_reg
    task automatic final_report;
        $display("checks=%0d failures=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_n
    // Expected {oe_n, out & drive} by pin precedence
    function automatic logic [7:0] exp_pins();
        logic [3:0] o, d;
        for (int i = 0; i < 4; i++)
        begin
            d[i] = dir[i];
            o[i] = dat[i];
            if (pwe[i] & ~hs[i] & ~ls[i])
            begin
                o[i] = pwo[i];
                d[i] = 1'b1;
            end
            if (tce[i] & ~hs[i] & ~ls[i])
            begin
                o[i] = tco[i];
                d[i] = 1'b1;
            end
            if (i > 1 && lin_en[i%2])
            begin
                o[i] = lin_o[i%2];
                d[i] = lin_d[i%2];
            end
            if (i > 1 && spi_en)
            begin
                o[i] = spi_o[i%2];
                d[i] = spi_d[i%2];
            end
            if (i == 1 && ldt_en)
            begin
                o[i] = ldt;
                d[i] = 1'b1;
            end
            if (i < 2 && sci_en)
            begin
                o[i] = sci_o[i%2];
                d[i] = sci_d[i%2];
            end
        end
        return {~d, o & d};
    endfunction : exp_pins
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            fail_count++;
            final_report();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(32'h2a3e));
        repeat (5) @(posedge clk);
        rst <= 0;
        rd_reg(OFF_PT_DIR, e);
        chk(e, 8'h00);
        rd_reg(OFF_IRQ_CTRL, e);
        chk(e & 8'hc0, 8'h40);
        rd_reg(16'h0242, e);
        chk(e, 8'h00);
        e[0] = ckp;
        wait_n(2);
        chk(ckp ^ e[0], 8'h00);
        e[0] = ckp;
        wait_n(1);
        chk(ckp ^ e[0], 8'h01);
        wr_reg(OFF_CLK_CTRL, 8'h80);
        wait_n(3);
        e[0] = ckp;
        wait_n(1);
        chk({ckp, e[0]}, 8'h00);
        wr_reg(OFF_CLK_CTRL, 8'h00);
        wr_reg(OFF_MISC, 8'h80);
        wait_n(2);
        chk(ocp, 8'h01);
        wr_reg(OFF_MISC, 8'h00);
        wait_n(2);
        chk(ocp, 8'h00);
        wr_reg(OFF_TEST, 8'h5a);
        rd_reg(OFF_TEST, e);
        chk(e, 8'h00);
        @(posedge clk) irq <= 0;
        wait_n(5);
        chk(req, 8'h01);
        @(posedge clk) irq <= 1;
        wait_n(5);
        chk(req, 8'h00);
        wr_reg(OFF_IRQ_CTRL, 8'h00);
        @(posedge clk) irq <= 0;
        wait_n(5);
        chk(req, 8'h00);
        @(posedge clk) irq <= 1;
        wr_reg(OFF_IRQ_CTRL, 8'hc0);
        rd_reg(OFF_IRQ_CTRL, e);
        chk(e & 8'hc0, 8'h40);
        @(posedge clk) spm <= 1;
        wr_reg(OFF_IRQ_CTRL, 8'hc0);
        rd_reg(OFF_IRQ_CTRL, e);
        chk(e & 8'hc0, 8'hc0);
        wr_reg(OFF_TEST, 8'h5a);
        rd_reg(OFF_TEST, e);
        chk(e, 8'h5a);
        @(posedge clk) irq <= 0;
        wait_n(5);
        chk(req, 8'h01);
        @(posedge clk) irq <= 1;
        wait_n(5);
        chk(req, 8'h01);
        @(posedge clk) svc <= 1;
        @(posedge clk) svc <= 0;
        wait_n(3);
        chk(req, 8'h00);
        for (int n = 0; n < 150; n++)
        begin
            dir = 4'($urandom);
            dat = 4'($urandom);
            wr_reg(OFF_PT_DIR, {4'h0, dir});
            wr_reg(OFF_PT_DATA, {4'h0, dat});
            @(posedge clk);
            {spi_en, sci_en, ldt_en, ldt} <= (n < 20) ? 4'h0 : 4'($urandom);
            {spi_o, spi_d, lin_en, lin_o} <= 8'($urandom);
            {lin_d, sci_o, sci_d} <= 6'($urandom);
            {tce, tco, pwe, pwo} <= (n < 20) ? 16'h0 : 16'($urandom);
            {hs, ls, lrx, ext} <= 16'($urandom);
            wait_n(6);
            e = exp_pins();
            chk(poe, e[7:4]);
            chk(pout & ~poe, e[3:0]);
            epin = (~e[7:4] & e[3:0]) | (e[7:4] & ext);
            chk({4'h0, cap}, {4'h0, epin & ~lrx});
            rd_reg(OFF_PT_DATA, e);
            chk(e, {4'h0, (dir & dat) | (~dir & epin)});
            rd_reg(OFF_PT_INPUT, e);
            chk(e, {4'h0, epin});
        end
        final_report();
    end
endmodule : ptpin_top_tb
